// file: bench/iswc_ctl_model.sv
`timescale 1ns/100ps
module iswc_ctl_model (
  input wire logic scl_w_i,
  input wire logic sda_w_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end

  task automatic rise(input int lo, output logic v);
    #(lo) scl_low_o = 1'b0;
    // no polling step, so an unstretched bit keeps its exact period
    wait (scl_w_i === 1'b1);
    #200 v = sda_w_i;
    #200 scl_low_o = 1'b1;
  endtask

  task automatic xfer(input logic [7:0] b, output logic ack);
    logic v;
    sda_low_o = 1'b1;
    #400 scl_low_o = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      #100 sda_low_o = ~b[i];
      rise(300, v);
    end
    // long low phase leaves the target room to stretch
    #100 sda_low_o = 1'b0;
    rise(700, ack);
    ack = ~ack;
  endtask

  task automatic stop();
    #100 sda_low_o = 1'b1;
    #300 scl_low_o = 1'b0;
    #300 sda_low_o = 1'b0;
    #400;
  endtask
endmodule

// file: bench/iswc_top_bench.sv
`timescale 1ns/100ps
`include "iswc_defs.svh"
module iswc_top_bench;
  import iswc_pkg::*;
  logic mclk, resetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, scl_w, sda_w;
  logic tx_trig, rx_trig, tx_clr, rx_clr, tx_frz, rx_frz, tgt_en, ctl_en, int_run, hand, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, tx_lvl, rx_lvl;
  logic [1:0] r;
  iswc_resp_t bresp, rresp;
  iswc_pwr_e pwr;
  int failures, n_tests, cyc;
  logic [7:0] offs [6];
  logic [31:0] msk [6];
  logic [31:0] v [6];

  assign scl_w = ~(m_scl | (scl_oe & ~scl_o));
  assign sda_w = ~(m_sda | (sda_oe & ~sda_o));

  iswc_top iswc_top_inst (.mclk_i(mclk), .resetn_i(resetn), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe), .sda_o(sda_o), .sda_oe_o(sda_oe), .pwr_state_i(pwr),
    .tx_level_i(tx_lvl), .rx_level_i(rx_lvl), .tx_trigger_o(tx_trig),
    .rx_trigger_o(rx_trig), .tx_clear_o(tx_clr), .rx_clear_o(rx_clr), .tx_freeze_o(tx_frz),
    .rx_freeze_o(rx_frz), .target_en_o(tgt_en), .controller_en_o(ctl_en),
    .int_run_o(int_run), .handoff_o(hand), .irq_o(irq));

  iswc_ctl_model iswc_ctl_model_inst (.scl_w_i(scl_w), .sda_w_i(sda_w),
    .scl_low_o(m_scl), .sda_low_o(m_sda));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic summarize();
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [1:0] trig_exp(logic [2:0] t, logic [3:0] tl, logic [3:0] rl);
    return {tl < {1'b0, t}, rl > {1'b0, t}};
  endfunction

  // handshakes are sampled mid-cycle, released after the edge that took them
  task automatic wr(input logic [7:0] a, input logic [31:0] dd);
    logic ta, tw, done;
    done = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= dd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(negedge mclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      done = bvalid === 1'b1;
      r = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, done;
    done = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(negedge mclk);
      ta = arvalid & arready;
      done = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
  endtask

  task automatic wake(input logic [31:0] pc, input logic [31:0] bc, input iswc_pwr_e p,
                      input logic [7:0] b, input logic ea, input logic ec);
    logic ack;
    int n;
    n = 0;
    wr(`ISWC_OFF_PROTO, pc);
    wr(`ISWC_OFF_BLK, bc);
    pwr <= p;
    // frames start off the sampling edge, so pin changes never race the synchroniser before a stretch release
    repeat (4) @(negedge mclk);
    fork
      iswc_ctl_model_inst.xfer(b, ack);
      if (p == PWR_DEEP && !pc[14] && ea)
      begin
        while (scl_oe !== 1'b1 && n < 2000)
        begin
          @(negedge mclk);
          n++;
        end
        repeat (30) @(negedge mclk);
        chk(32'({scl_w, irq}), 32'h1);
        @(posedge mclk);
        pwr <= PWR_ACTIVE;
        while (scl_oe === 1'b1 && n < 4000)
        begin
          @(negedge mclk);
          n++;
        end
        chk(32'(sda_oe), 32'h1);
      end
    join
    repeat (8) @(negedge mclk);
    chk(32'({ack, hand}), 32'({ea, ea}));
    iswc_ctl_model_inst.stop();
    repeat (4) @(negedge mclk);
    chk(32'({irq, int_run}),
        32'({ec && pwr != PWR_ACTIVE, bc[31] && !bc[0] && pwr != PWR_DEEP}));
    // after a refusal nobody readdresses until awake
    @(posedge mclk);
    pwr <= PWR_ACTIVE;
    rd(`ISWC_OFF_CAUSE);
    chk(d, 32'(ec));
    wr(`ISWC_OFF_CAUSE, 32'h1);
  endtask

  initial
  begin
    logic [2:0] t;
    logic [3:0] tl, rl;
    logic run_e;
    {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, tx_lvl, rx_lvl, cyc, failures, n_tests} = '0;
    wstrb = 4'hF;
    pwr = PWR_ACTIVE;
    offs = '{`ISWC_OFF_PROTO, `ISWC_OFF_TXF, `ISWC_OFF_RXF, `ISWC_OFF_TXQ, `ISWC_OFF_RXQ,
             `ISWC_OFF_BLK};
    msk = '{`ISWC_M_PROTO, `ISWC_M_TXF, `ISWC_M_RXF, `ISWC_M_QUEUE, `ISWC_M_QUEUE, `ISWC_M_BLK};
    void'($urandom(97053));
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int a = 0; a < 44; a += 4)
    begin
      rd(8'(a));
      // status shows both idle lines high, the rest of the map resets to zero
      chk(d, (a == `ISWC_OFF_STAT) ? 32'h0000_000C : 32'h0000_0000);
      chk(32'(r), (a < 40) ? 32'(`ISWC_RESP_OKAY) : 32'(`ISWC_RESP_SLVERR));
    end
    wr(8'h28, $urandom);
    chk(32'(r), 32'(`ISWC_RESP_SLVERR));
    for (int i = 0; i < 6; i++)
    begin
      v[i] = $urandom;
      wr(offs[i], v[i]);
      rd(offs[i]);
      chk(d, v[i] & msk[i]);
    end
    @(negedge mclk);
    // roles run only when enabled, in i2c mode, with a valid clock pairing
    run_e = v[5][31] && (v[5][25:24] == 2'h0) && (v[5][1] || !v[5][0]);
    chk(32'({ctl_en, tgt_en, int_run, tx_clr, tx_frz, rx_clr, rx_frz}),
        32'({run_e && v[0][31] && !v[5][0], run_e && v[0][30], run_e && !v[5][0],
        v[3][16], v[3][17], v[4][16], v[4][17]}));
    wr(`ISWC_OFF_BLK, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      t = (i == 0) ? 3'h7 : 3'($urandom);
      tl = (i == 0) ? 4'h7 : 4'($urandom);
      rl = (i == 0) ? 4'h7 : 4'($urandom);
      wr(`ISWC_OFF_TXQ, {29'h0, t});
      wr(`ISWC_OFF_RXQ, {29'h0, t});
      tx_lvl <= tl;
      rx_lvl <= rl;
      repeat (3) @(negedge mclk);
      chk(32'({tx_trig, rx_trig}), 32'(trig_exp(t, tl, rl)));
    end
    // role, frames, queues, address, mask, then block; op clock select is 0 except in the invalid-pairing wake
    wr(`ISWC_OFF_PROTO, 32'h4000_4000);
    wr(`ISWC_OFF_TXF, 32'h8000_0107);
    wr(`ISWC_OFF_RXF, 32'h8000_0107);
    wr(`ISWC_OFF_TXQ, 32'h0);
    wr(`ISWC_OFF_RXQ, 32'h0);
    wr(`ISWC_OFF_SADDR, 32'h2A);
    wr(`ISWC_OFF_MASK, 32'h1);
    wake(32'h4000_4000, 32'h8000_0002, PWR_DEEP, 8'h54, 1'b0, 1'b1);
    wake(32'h4000_0000, 32'h8000_0002, PWR_DEEP, 8'h54, 1'b1, 1'b1);
    wake(32'h4000_0000, 32'h8000_0002, PWR_ACTIVE, 8'h56, 1'b0, 1'b0);
    wake(32'h4000_0000, 32'h8000_0001, PWR_ACTIVE, 8'h54, 1'b0, 1'b0);
    wake(32'h4000_0000, 32'h8000_0002, PWR_SLEEP, 8'h54, 1'b1, 1'b1);
    wr(`ISWC_OFF_RXF, 32'h8000_0307);
    wake(32'h4000_0000, 32'h8000_0002, PWR_ACTIVE, 8'h54, 1'b1, 1'b1);
    summarize();
  end
endmodule

// file: hw/iswc_defs.svh
`ifndef ISWC_DEFS_SVH
`define ISWC_DEFS_SVH

// register byte offsets
`define ISWC_OFF_PROTO 8'h00
`define ISWC_OFF_TXF 8'h04
`define ISWC_OFF_RXF 8'h08
`define ISWC_OFF_TXQ 8'h0C
`define ISWC_OFF_RXQ 8'h10
`define ISWC_OFF_BLK 8'h14
`define ISWC_OFF_CAUSE 8'h18
`define ISWC_OFF_MASK 8'h1C
`define ISWC_OFF_SADDR 8'h20
`define ISWC_OFF_STAT 8'h24

// field positions
`define ISWC_TARGET_BIT 30
`define ISWC_CTRLR_BIT 31
`define ISWC_NACK_SEL_BIT 14
`define ISWC_MSB_FIRST_BIT 8
`define ISWC_MEDIAN_BIT 9
`define ISWC_ENABLE_BIT 31
`define ISWC_CLEAR_BIT 16
`define ISWC_FREEZE_BIT 17
`define ISWC_OP_SEL_BIT 0
`define ISWC_AM_SEL_BIT 1
`define ISWC_WAKE_BIT 0

// writable bits, everything else reads zero
`define ISWC_M_PROTO 32'hC000_4000
`define ISWC_M_TXF 32'h8000_010F
`define ISWC_M_RXF 32'h8000_030F
`define ISWC_M_QUEUE 32'h0003_0007
`define ISWC_M_BLK 32'h8300_0003

`define ISWC_RST_REG 32'h0000_0000
`define ISWC_RST_SADDR 7'h00
`define ISWC_MODE_I2C 2'h0
`define ISWC_RESP_OKAY 2'h0
`define ISWC_RESP_SLVERR 2'h2

`endif

// file: hw/iswc_line_filter.sv
`timescale 1ns/100ps
module iswc_line_filter #(
  parameter int W = 2
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] pins_i,
  input wire logic median_en_i,
  output logic [W-1:0] lines_o
);
  logic [W-1:0] sync1_q;
  logic [W-1:0] sync2_q;
  logic [W-1:0] tap1_q;
  logic [W-1:0] tap2_q;
  logic [W-1:0] vote;

  // idle bus lines sit high, so everything resets to ones
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_q <= {W{1'b1}};
      sync2_q <= {W{1'b1}};
      tap1_q <= {W{1'b1}};
      tap2_q <= {W{1'b1}};
      lines_o <= {W{1'b1}};
    end
    else
    begin
      sync1_q <= pins_i;
      sync2_q <= sync1_q;
      tap1_q <= sync2_q;
      tap2_q <= tap1_q;
      lines_o <= median_en_i ? vote : sync2_q;
    end
  end

  // three-tap majority, costs one extra cycle of latency on each edge
  assign vote = (sync2_q & tap1_q) | (sync2_q & tap2_q) | (tap1_q & tap2_q);

endmodule

// file: hw/iswc_pkg.sv
package iswc_pkg;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_SLEEP = 2'h1,
    PWR_DEEP = 2'h2
  } iswc_pwr_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADEC = 3'h2,
    ST_ACK = 3'h3,
    ST_NACK = 3'h4,
    ST_STRETCH = 3'h5,
    ST_HOLD = 3'h6,
    ST_SKIP = 3'h7
  } iswc_state_e;

  typedef logic [1:0] iswc_resp_t;

endpackage

// file: hw/iswc_top.sv
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "iswc_defs.svh"

module iswc_top #(
  parameter int LVL_W = 4
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output iswc_pkg::iswc_resp_t s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output iswc_pkg::iswc_resp_t s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  input wire iswc_pkg::iswc_pwr_e pwr_state_i,
  input wire logic [LVL_W-1:0] tx_level_i,
  input wire logic [LVL_W-1:0] rx_level_i,
  output logic tx_trigger_o,
  output logic rx_trigger_o,
  output logic tx_clear_o,
  output logic rx_clear_o,
  output logic tx_freeze_o,
  output logic rx_freeze_o,
  output logic target_en_o,
  output logic controller_en_o,
  output logic int_run_o,
  output logic handoff_o,
  output logic irq_o
);
  import iswc_pkg::*;

  function automatic logic [7:0] align(input logic [7:0] a);
    align = {a[7:2], 2'h0};
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    wmerge = r;
  endfunction

  logic [31:0] proto_q;
  logic [31:0] txf_q;
  logic [31:0] rxf_q;
  logic [31:0] txq_q;
  logic [31:0] rxq_q;
  logic [31:0] blk_q;
  logic [6:0] saddr_q;
  logic mask_q;
  logic cause_q;
  logic cause_d;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] rd_word;
  logic rd_hit;
  iswc_state_e st_q;
  iswc_state_e st_d;
  logic [3:0] cnt_q;
  logic [15:0] sh_q;
  logic scl_f;
  logic sda_f;
  logic scl_p_q;
  logic sda_p_q;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  // register bus decode
  wire wr_en = aw_have_q && w_have_q && !s_axi_bvalid_o;
  wire [7:0] aw_al = align(awaddr_q);
  wire [7:0] ar_al = align(s_axi_araddr_i);
  wire [31:0] wword = wmerge(32'h0000_0000, wdata_q, wstrb_q);
  wire ar_take = s_axi_arvalid_i && s_axi_arready_o;
  wire wr_map = (aw_al <= `ISWC_OFF_STAT);

  // configuration decode
  wire blk_en = blk_q[`ISWC_ENABLE_BIT];
  wire mode_i2c = (blk_q[25:24] == `ISWC_MODE_I2C);
  wire am_ext = blk_q[`ISWC_AM_SEL_BIT];
  wire op_ext = blk_q[`ISWC_OP_SEL_BIT];
  wire awake = (pwr_state_i != PWR_DEEP);
  wire nack_sel = proto_q[`ISWC_NACK_SEL_BIT];
  wire cfg_bad = !am_ext && op_ext;
  wire run = blk_en && mode_i2c && !cfg_bad;
  wire em_run = run && am_ext && proto_q[`ISWC_TARGET_BIT]
                && txf_q[`ISWC_ENABLE_BIT] && rxf_q[`ISWC_ENABLE_BIT];

  // line conditions on the filtered, synchronised lines
  wire scl_rise = scl_f && !scl_p_q;
  wire scl_fall = !scl_f && scl_p_q;
  wire start = scl_f && scl_p_q && sda_p_q && !sda_f;
  wire stop = scl_f && scl_p_q && !sda_p_q && sda_f;
  wire msb_first = rxf_q[`ISWC_MSB_FIRST_BIT];
  wire [7:0] rx_byte = msb_first ? sh_q[7:0] : sh_q[15:8];
  wire match = (rx_byte[7:1] == saddr_q);
  wire match_ev = em_run && (st_q == ST_ADEC) && scl_fall && match
                  && !start && !stop;

  iswc_line_filter #(
    .W(2)
  ) u_filter (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .pins_i({scl_i, sda_i}),
    .median_en_i(rxf_q[`ISWC_MEDIAN_BIT]),
    .lines_o({scl_f, sda_f})
  );

  // write channel: address and data taken independently
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `ISWC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_en)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_map ? `ISWC_RESP_OKAY : `ISWC_RESP_SLVERR;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  // ready is low while a word is held, so it stays registered
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
    end
    else
    begin
      s_axi_awready_o <= !(aw_have_q || (s_axi_awvalid_i && s_axi_awready_o))
                         || (s_axi_bvalid_o && s_axi_bready_i);
      s_axi_wready_o <= !(w_have_q || (s_axi_wvalid_i && s_axi_wready_o))
                        || (s_axi_bvalid_o && s_axi_bready_i);
    end
  end

  // a_bus_write_answer: response one cycle after the write lands
  a_bus_write_answer: assert property (wr_en |=> s_axi_bvalid_o)
    else $error("write response missing");

  // configuration registers
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      proto_q <= `ISWC_RST_REG;
      txf_q <= `ISWC_RST_REG;
      rxf_q <= `ISWC_RST_REG;
      txq_q <= `ISWC_RST_REG;
      rxq_q <= `ISWC_RST_REG;
      blk_q <= `ISWC_RST_REG;
      saddr_q <= `ISWC_RST_SADDR;
      mask_q <= 1'b0;
    end
    else if (wr_en)
    begin
      if (aw_al == `ISWC_OFF_PROTO)
        proto_q <= wmerge(proto_q, wdata_q, wstrb_q) & `ISWC_M_PROTO;
      if (aw_al == `ISWC_OFF_TXF)
        txf_q <= wmerge(txf_q, wdata_q, wstrb_q) & `ISWC_M_TXF;
      if (aw_al == `ISWC_OFF_RXF)
        rxf_q <= wmerge(rxf_q, wdata_q, wstrb_q) & `ISWC_M_RXF;
      if (aw_al == `ISWC_OFF_TXQ)
        txq_q <= wmerge(txq_q, wdata_q, wstrb_q) & `ISWC_M_QUEUE;
      if (aw_al == `ISWC_OFF_RXQ)
        rxq_q <= wmerge(rxq_q, wdata_q, wstrb_q) & `ISWC_M_QUEUE;
      if (aw_al == `ISWC_OFF_BLK)
        blk_q <= wmerge(blk_q, wdata_q, wstrb_q) & `ISWC_M_BLK;
      if ((aw_al == `ISWC_OFF_SADDR) && wstrb_q[0])
        saddr_q <= wdata_q[6:0];
      if ((aw_al == `ISWC_OFF_MASK) && wstrb_q[0])
        mask_q <= wdata_q[`ISWC_WAKE_BIT];
    end
  end

  // wake cause, set beats a same-cycle write-one clear
  assign cause_d = match_ev || (cause_q && !(wr_en && (aw_al == `ISWC_OFF_CAUSE)
                   && wword[`ISWC_WAKE_BIT]));

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cause_q <= 1'b0;
    else
      cause_q <= cause_d;
  end

  // a_wake_cause_set: a match always leaves the cause bit set
  a_wake_cause_set: assert property (match_ev |=> cause_q)
    else $error("wake cause not set on match");

  // read path
  always_comb
  begin
    rd_hit = 1'b1;
    case (ar_al)
      `ISWC_OFF_PROTO: rd_word = proto_q;
      `ISWC_OFF_TXF: rd_word = txf_q;
      `ISWC_OFF_RXF: rd_word = rxf_q;
      `ISWC_OFF_TXQ: rd_word = txq_q;
      `ISWC_OFF_RXQ: rd_word = rxq_q;
      `ISWC_OFF_BLK: rd_word = blk_q;
      `ISWC_OFF_CAUSE: rd_word = {31'h0000_0000, cause_q};
      `ISWC_OFF_MASK: rd_word = {31'h0000_0000, mask_q};
      `ISWC_OFF_SADDR: rd_word = {25'h000_0000, saddr_q};
      `ISWC_OFF_STAT: rd_word = {22'h00_0000, handoff_o, int_run_o, cfg_bad,
                                 st_q, scl_f, sda_f, tx_trigger_o, rx_trigger_o};
      default:
      begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `ISWC_RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= rd_hit ? `ISWC_RESP_OKAY : `ISWC_RESP_SLVERR;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // externally clocked address matcher
  always_comb
  begin
    st_d = st_q;
    if (!em_run || stop)
      st_d = ST_IDLE;
    else if (start)
      st_d = ST_ADDR;
    else
      case (st_q)
        // frame ends after field plus one bits
        ST_ADDR: if (scl_rise && (cnt_q == rxf_q[3:0])) st_d = ST_ADEC;
        ST_ADEC:
        begin
          if (scl_fall)
            st_d = !match ? ST_SKIP : awake ? ST_ACK
                   : nack_sel ? ST_NACK : ST_STRETCH;
        end
        ST_ACK: if (scl_fall) st_d = ST_HOLD;
        ST_NACK: if (scl_fall) st_d = ST_SKIP;
        ST_STRETCH: if (awake) st_d = ST_ACK;
        default: st_d = st_q;
      endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 16'h0000;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      if (start)
        cnt_q <= 4'h0;
      else if ((st_q == ST_ADDR) && scl_rise)
      begin
        cnt_q <= cnt_q + 4'h1;
        sh_q <= msb_first ? {sh_q[14:0], sda_f} : {sda_f, sh_q[15:1]};
      end
    end
  end

  // pin drive, registered off the next state; both lines only pull low
  // the ack and clock release share an edge: the controller samples
  // data 200 ns after its next clock rise, two cycles later
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      handoff_o <= 1'b0;
    end
    else
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_o <= (st_d == ST_STRETCH);
      sda_oe_o <= (st_d == ST_ACK);
      handoff_o <= (st_d == ST_HOLD);
    end
  end

  sequence s_woke_in_stretch;
    (st_q == ST_STRETCH) && awake && em_run && !stop && !start;
  endsequence

  // a_stretch_then_ack: wake releases the clock and acks together
  a_stretch_then_ack: assert property (s_woke_in_stretch |=>
    (st_q == ST_ACK) && sda_oe_o && !scl_oe_o)
    else $error("no ack after stretch wake");

  // a_stretch_holds_scl: clock stays low through the stretch
  a_stretch_holds_scl: assert property ((st_q == ST_STRETCH) |-> scl_oe_o)
    else $error("clock not held during stretch");

  // a_nack_path: deep-sleep match with bit 14 gives a released data line
  a_nack_path: assert property (match_ev && !awake && nack_sel |=>
    (st_q == ST_NACK) && !sda_oe_o && !scl_oe_o)
    else $error("nack not given while asleep");

  // a_ack_hands_over: ack ends with internal logic owning the bus
  a_ack_hands_over: assert property ((st_q == ST_ACK) && scl_fall && em_run
    && !stop && !start |=> handoff_o)
    else $error("no handoff after ack");

  // a_frame_length: matcher decides after field plus one bits
  a_frame_length: assert property ((st_q == ST_ADDR) && scl_rise && em_run
    && !start && !stop && (cnt_q == rxf_q[3:0]) |=> (st_q == ST_ADEC))
    else $error("frame length miscounted");

  // queue controls and role outputs
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tx_trigger_o <= 1'b0;
      rx_trigger_o <= 1'b0;
      tx_clear_o <= 1'b0;
      rx_clear_o <= 1'b0;
      tx_freeze_o <= 1'b0;
      rx_freeze_o <= 1'b0;
      target_en_o <= 1'b0;
      controller_en_o <= 1'b0;
      int_run_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      tx_trigger_o <= (tx_level_i < LVL_W'(txq_q[2:0]));
      rx_trigger_o <= (rx_level_i > LVL_W'(rxq_q[2:0]));
      tx_clear_o <= txq_q[`ISWC_CLEAR_BIT];
      rx_clear_o <= rxq_q[`ISWC_CLEAR_BIT];
      tx_freeze_o <= txq_q[`ISWC_FREEZE_BIT];
      rx_freeze_o <= rxq_q[`ISWC_FREEZE_BIT];
      target_en_o <= run && proto_q[`ISWC_TARGET_BIT];
      controller_en_o <= run && proto_q[`ISWC_CTRLR_BIT] && !op_ext;
      // internal logic stops in deep sleep
      int_run_o <= run && !op_ext && awake;
      irq_o <= cause_q && mask_q && (pwr_state_i != PWR_ACTIVE);
    end
  end

  // a_tx_trigger: fewer entries than the level raises the trigger
  a_tx_trigger: assert property ((tx_level_i < LVL_W'(txq_q[2:0]))
    |=> tx_trigger_o)
    else $error("transmit trigger missing");

  // a_queue_clear_freeze: controls follow their bits next cycle
  a_queue_clear_freeze: assert property (rxq_q[`ISWC_CLEAR_BIT]
    && txq_q[`ISWC_FREEZE_BIT] |=> rx_clear_o && tx_freeze_o)
    else $error("clear or freeze not applied");

  // a_invalid_silent: bad clock pairing never drives or runs
  a_invalid_silent: assert property (cfg_bad [*2] |-> !sda_oe_o && !scl_oe_o
    && !int_run_o && !target_en_o)
    else $error("block active in invalid clocking");

  // a_role_target: target role follows its select bit
  a_role_target: assert property (run && proto_q[`ISWC_TARGET_BIT]
    |=> target_en_o)
    else $error("target role not enabled");

  // a_ctrl_internal: controller never runs with external operation
  a_ctrl_internal: assert property (controller_en_o |-> !$past(op_ext))
    else $error("controller on external clock");

  // a_deep_sleep_stop: internal logic off in deep sleep
  a_deep_sleep_stop: assert property ((pwr_state_i == PWR_DEEP)
    |=> !int_run_o)
    else $error("internal logic ran in deep sleep");

  // a_mode_gate: non-i2c mode or disabled block stops the controller role, internal logic and matcher
  a_mode_gate: assert property (!(blk_en && mode_i2c) [*2] |->
    !int_run_o && !controller_en_o && (st_q == ST_IDLE))
    else $error("block ran while disabled");

  // a_irq_or: interrupt follows the enabled cause in the sleep state
  a_irq_or: assert property (cause_q && mask_q && (pwr_state_i == PWR_SLEEP)
    |=> irq_o)
    else $error("interrupt not raised");

  // a_active_masks: no wake interrupt while active
  a_active_masks: assert property ((pwr_state_i == PWR_ACTIVE) |=> !irq_o)
    else $error("wake interrupt while active");

endmodule
